/* File: verilog/afs_pkg.sv */
// package: register map, field positions and reset values of the amplifier fault block
package afs_pkg;
  // printed offsets are not all multiples of four: they are word indices, byte address = 4 * index
  localparam logic [7:0] IDX_CHANNEL_FAULT_STATUS = 8'h70;
  localparam logic [7:0] IDX_DEV_FAULT_A = 8'h71;
  localparam logic [7:0] IDX_DEV_FAULT_B = 8'h72;
  localparam logic [7:0] IDX_THERM_WARN = 8'h73;
  localparam logic [7:0] IDX_REPORT_MASK = 8'h74;
  localparam logic [7:0] IDX_LATCH_CFG = 8'h75;
  localparam logic [7:0] IDX_BEHAV_CFG = 8'h76;
  localparam logic [7:0] IDX_FAULT_CLR = 8'h78;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h7C;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h7D;
  localparam int ADDR_W = 10;
  // channel fault field positions
  localparam int CH_LEFT_DC = 3;
  localparam int CH_RIGHT_DC = 2;
  localparam int CH_LEFT_OC = 1;
  localparam int CH_RIGHT_OC = 0;
  // device fault a
  localparam int DA_CRC = 7;
  localparam int DA_COEF_WR = 6;
  localparam int DA_CLK = 2;
  localparam int DA_PVDD_OV = 1;
  localparam int DA_PVDD_UV = 0;
  // device fault b and thermal warning
  localparam int DB_OTSD = 0;
  localparam int TW_OTW = 2;
  // report mask
  localparam int MK_OTSD = 7;
  localparam int MK_CORE_UV = 6;
  localparam int MK_CORE_OV = 5;
  localparam int MK_CLK = 4;
  localparam int MK_PWR_UV = 3;
  localparam int MK_PWR_OV = 2;
  localparam int MK_DC = 1;
  localparam int MK_OC = 0;
  // latch config
  localparam int LC_CLK_LATCH = 5;
  localparam int LC_OTSD_LATCH = 4;
  localparam int LC_OTW_LATCH = 3;
  localparam int LC_OTW_MASK = 2;
  // behaviour config
  localparam int BC_CLKDET_LATCH = 7;
  localparam int BC_AUTO_REC = 4;
  // clear command
  localparam int FC_ANALOG_CLR = 7;
  // reset values
  localparam logic [7:0] RST_REPORT_MASK = 8'h00;
  localparam logic [7:0] RST_LATCH_CFG = 8'hF8;
  localparam logic [7:0] RST_BEHAV_CFG = 8'h00;
  localparam logic [7:0] RST_FAULT_CLR_RES = 8'h00;
  // interrupt status bits
  localparam int IRQ_W = 6;
  localparam int IR_DC = 0;
  localparam int IR_OC = 1;
  localparam int IR_SUPPLY = 2;
  localparam int IR_CLK = 3;
  localparam int IR_OTSD = 4;
  localparam int IR_OTW = 5;
endpackage : afs_pkg

/* File: verilog/afs_fault_regs.sv */
// fault status and fault handling register bank of a class d amplifier, apb slave
// How it works
// - channel fault status reads left dc in bit 3, right dc in bit 2, left oc in bit 1, right oc in bit 0.
// - device fault a reads crc error in bit 7, clock fault in bit 2, supply ov in bit 1, supply uv in bit 0.
// - device fault a bit 6 is set when the latest coefficient write failed.
// - device fault b reports thermal shutdown in bit 0, other bits read zero.
// - thermal warning status bit 2 flags the 135 C warning threshold.
// - a set report mask bit suppresses its fault group; all mask bits reset to zero.
// - thermal shutdown and thermal warning latch when their enables (4,3) are set, clock fault when enable 5 and behaviour bit 7 are set; enables default on.
// - latch config bit 2 suppresses the thermal warning report; it resets to zero.
// - behaviour config bit 7 set latches the clock detect status, clear leaves it live.
// - behaviour config bit 4 lets the device leave thermal shutdown on its own, default off.
// - writing one to clear register bit 7 clears latched analog faults; the bit is not stored.
//
// Design decision made here: the APB register port.
`timescale 1ns/1ps
module afs_fault_regs
  import afs_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // apb
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [afs_pkg::ADDR_W-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  output logic o_pready,
  output logic o_pslverr,
  output logic [31:0] o_prdata,
  // raw fault conditions from the analog side (asynchronous)
  input wire logic i_left_dc_fault,
  input wire logic i_right_dc_fault,
  input wire logic i_left_overcurrent_fault,
  input wire logic i_right_overcurrent_fault,
  input wire logic i_crc_error,
  input wire logic i_coef_write_failure,
  input wire logic i_clock_fault,
  input wire logic i_power_supply_overvoltage,
  input wire logic i_power_supply_undervoltage,
  input wire logic i_core_supply_overvoltage,
  input wire logic i_core_supply_undervoltage,
  input wire logic i_thermal_shutdown_fault,
  input wire logic i_thermal_warning_flag,
  // fault handling outputs
  output logic o_shutdown_hold,
  output logic o_fault_report,
  output logic o_irq
);
  import afs_pkg::*;

  localparam int NSYNC = 13;

  typedef struct packed {
    logic [NSYNC-1:0] s1;
    logic [NSYNC-1:0] s2;
    logic [7:0] mask;
    logic [7:0] latch_cfg;
    logic [7:0] behav_cfg;
    logic clk_lat;
    logic otsd_lat;
    logic otw_lat;
    logic shut_hold;
    logic [IRQ_W-1:0] irq_st;
    logic [IRQ_W-1:0] irq_mask;
    logic [IRQ_W-1:0] prev_ev;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic report;
    logic irq;
  } afs_state_t;

  afs_state_t s_q;
  afs_state_t s_d;

  logic [NSYNC-1:0] raw;
  assign raw = {
    i_thermal_warning_flag,
    i_thermal_shutdown_fault,
    i_core_supply_undervoltage,
    i_core_supply_overvoltage,
    i_power_supply_undervoltage,
    i_power_supply_overvoltage,
    i_clock_fault,
    i_coef_write_failure,
    i_crc_error,
    i_right_overcurrent_fault,
    i_left_overcurrent_fault,
    i_right_dc_fault,
    i_left_dc_fault
  };

  // synchronised views (second flop only), so no logic ever sees a metastable first stage
  logic l_ldc;
  logic l_rdc;
  logic l_loc;
  logic l_roc;
  logic l_crc;
  logic l_bq;
  logic l_clk;
  logic l_pov;
  logic l_puv;
  logic l_cov;
  logic l_cuv;
  logic l_otsd;
  logic l_otw;
  assign l_ldc = s_q.s2[0];
  assign l_rdc = s_q.s2[1];
  assign l_loc = s_q.s2[2];
  assign l_roc = s_q.s2[3];
  assign l_crc = s_q.s2[4];
  assign l_bq = s_q.s2[5];
  assign l_clk = s_q.s2[6];
  assign l_pov = s_q.s2[7];
  assign l_puv = s_q.s2[8];
  assign l_cov = s_q.s2[9];
  assign l_cuv = s_q.s2[10];
  assign l_otsd = s_q.s2[11];
  assign l_otw = s_q.s2[12];

  logic acc;
  logic wr;
  logic rd;
  logic hit;
  logic [7:0] idx;
  logic [7:0] wb;
  logic clr_cmd;
  logic clk_view;
  logic otsd_view;
  logic otw_view;
  logic [7:0] chan_v;
  logic [7:0] dfa_v;
  logic [7:0] dfb_v;
  logic [7:0] tw_v;
  logic [7:0] rdv;
  logic [IRQ_W-1:0] ev;

  assign acc = i_psel && i_penable;
  assign wr = acc && i_pwrite;
  assign rd = acc && !i_pwrite;
  assign idx = i_paddr[afs_pkg::ADDR_W-1:2];
  assign wb = i_pstrb[0] ? i_pwdata[7:0] : 8'h00;
  // self-clearing command: decoded from the write, never stored
  assign clr_cmd = wr && (idx == IDX_FAULT_CLR) && i_pstrb[0] && i_pwdata[FC_ANALOG_CLR];

  // latched views hold, live views follow the condition
  assign clk_view = s_q.clk_lat | l_clk;
  assign otsd_view = s_q.otsd_lat | l_otsd;
  assign otw_view = s_q.otw_lat | l_otw;

  always_comb begin
    chan_v = 8'h00;
    chan_v[CH_LEFT_DC] = l_ldc && !s_q.mask[MK_DC];
    chan_v[CH_RIGHT_DC] = l_rdc && !s_q.mask[MK_DC];
    chan_v[CH_LEFT_OC] = l_loc && !s_q.mask[MK_OC];
    chan_v[CH_RIGHT_OC] = l_roc && !s_q.mask[MK_OC];
    dfa_v = 8'h00;
    dfa_v[DA_CRC] = l_crc;
    dfa_v[DA_COEF_WR] = l_bq;
    dfa_v[DA_CLK] = clk_view && !s_q.mask[MK_CLK];
    dfa_v[DA_PVDD_OV] = l_pov && !s_q.mask[MK_PWR_OV];
    dfa_v[DA_PVDD_UV] = l_puv && !s_q.mask[MK_PWR_UV];
    dfb_v = 8'h00;
    dfb_v[DB_OTSD] = otsd_view && !s_q.mask[MK_OTSD];
    tw_v = 8'h00;
    tw_v[TW_OTW] = otw_view && !s_q.latch_cfg[LC_OTW_MASK];
  end

  // interrupt events: rising edge of each reported group
  assign ev = {tw_v[TW_OTW], dfb_v[DB_OTSD], dfa_v[DA_CLK],
               dfa_v[DA_PVDD_OV] | dfa_v[DA_PVDD_UV] | (l_cov & ~s_q.mask[MK_CORE_OV])
                 | (l_cuv & ~s_q.mask[MK_CORE_UV]),
               chan_v[CH_LEFT_OC] | chan_v[CH_RIGHT_OC], chan_v[CH_LEFT_DC] | chan_v[CH_RIGHT_DC]};

  always_comb begin
    hit = 1'b1;
    rdv = 8'h00;
    unique case (idx)
      IDX_CHANNEL_FAULT_STATUS: rdv = chan_v;
      IDX_DEV_FAULT_A: rdv = dfa_v;
      IDX_DEV_FAULT_B: rdv = dfb_v;
      IDX_THERM_WARN: rdv = tw_v;
      IDX_REPORT_MASK: rdv = s_q.mask;
      IDX_LATCH_CFG: rdv = s_q.latch_cfg;
      IDX_BEHAV_CFG: rdv = s_q.behav_cfg;
      IDX_FAULT_CLR: rdv = RST_FAULT_CLR_RES;
      IDX_IRQ_STATUS: rdv = {2'b00, s_q.irq_st};
      IDX_IRQ_MASK: rdv = {2'b00, s_q.irq_mask};
      default: hit = 1'b0;
    endcase
  end

  always_comb begin
    s_d = s_q;
    s_d.s1 = raw;
    s_d.s2 = s_q.s1;
    // apb: one wait state per access, answer registered so pready rises one cycle into access
    s_d.pready = acc && !s_q.pready;
    s_d.pslverr = acc && !s_q.pready && !hit;
    s_d.prdata = (rd && !s_q.pready && hit) ? {24'h000000, rdv} : 32'h0000_0000;
    if (wr && !s_q.pready && hit && i_pstrb[0]) begin
      unique case (idx)
        IDX_REPORT_MASK: s_d.mask = wb;
        IDX_LATCH_CFG: s_d.latch_cfg = wb;
        IDX_BEHAV_CFG: s_d.behav_cfg = wb;
        IDX_IRQ_MASK: s_d.irq_mask = wb[IRQ_W-1:0];
        default: ;
      endcase
    end
    // latches: the clear command wins only over history, a live fault re-sets at once
    if (clr_cmd && !s_q.pready) begin
      s_d.clk_lat = 1'b0;
      s_d.otsd_lat = 1'b0;
      s_d.otw_lat = 1'b0;
    end
    // clock latching needs both its own enable and the detect-latch option
    if (l_clk && s_q.latch_cfg[LC_CLK_LATCH] && s_q.behav_cfg[BC_CLKDET_LATCH]) s_d.clk_lat = 1'b1;
    if (l_otsd && s_q.latch_cfg[LC_OTSD_LATCH]) s_d.otsd_lat = 1'b1;
    if (l_otw && s_q.latch_cfg[LC_OTW_LATCH]) s_d.otw_lat = 1'b1;
    // shutdown hold: auto recovery releases as soon as the die cools
    if (l_otsd) s_d.shut_hold = 1'b1;
    else if (s_q.behav_cfg[BC_AUTO_REC]) s_d.shut_hold = 1'b0;
    else if (clr_cmd && !s_q.pready) s_d.shut_hold = 1'b0;
    // sticky interrupt bits, write one to clear, new event wins
    s_d.prev_ev = ev;
    if (wr && !s_q.pready && i_pstrb[0] && idx == IDX_IRQ_STATUS) s_d.irq_st = s_q.irq_st & ~wb[IRQ_W-1:0];
    s_d.irq_st = s_d.irq_st | (ev & ~s_q.prev_ev);
    s_d.irq = |(s_d.irq_st & s_d.irq_mask);
    s_d.report = |chan_v | |dfa_v | dfb_v[DB_OTSD] | tw_v[TW_OTW];
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      s_q <= '0;
      s_q.mask <= RST_REPORT_MASK;
      s_q.latch_cfg <= RST_LATCH_CFG;
      s_q.behav_cfg <= RST_BEHAV_CFG;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_pready = s_q.pready;
  assign o_pslverr = s_q.pslverr;
  assign o_prdata = s_q.prdata;
  assign o_shutdown_hold = s_q.shut_hold;
  assign o_fault_report = s_q.report;
  assign o_irq = s_q.irq;

  // configuration defaults right after reset
  a_mask_reset_val: assert property (@(posedge i_clk)
    $rose(i_resetn) |-> s_q.mask == RST_REPORT_MASK && s_q.latch_cfg == RST_LATCH_CFG)
    else $error("config reset values wrong");
  a_behav_reset_val: assert property (@(posedge i_clk)
    $rose(i_resetn) |-> s_q.behav_cfg == RST_BEHAV_CFG)
    else $error("behaviour config reset value wrong");

  // latches
  a_otsd_latch_hold: assert property (@(posedge i_clk) disable iff (!i_resetn)
    s_q.otsd_lat && !(clr_cmd && !s_q.pready) |=> s_q.otsd_lat)
    else $error("thermal shutdown latch dropped without clear");
  a_otsd_latch_set: assert property (@(posedge i_clk) disable iff (!i_resetn)
    l_otsd && s_q.latch_cfg[LC_OTSD_LATCH] |=> s_q.otsd_lat)
    else $error("thermal shutdown not latched");
  a_otw_latch_set: assert property (@(posedge i_clk) disable iff (!i_resetn)
    l_otw && s_q.latch_cfg[LC_OTW_LATCH] |=> s_q.otw_lat)
    else $error("thermal warning not latched");
  a_clk_latch_set: assert property (@(posedge i_clk) disable iff (!i_resetn)
    l_clk && s_q.latch_cfg[LC_CLK_LATCH] && s_q.behav_cfg[BC_CLKDET_LATCH] |=> s_q.clk_lat)
    else $error("clock fault not latched");
  a_clk_no_latch: assert property (@(posedge i_clk) disable iff (!i_resetn)
    !s_q.behav_cfg[BC_CLKDET_LATCH] && !s_q.clk_lat |=> !s_q.clk_lat)
    else $error("clock latched while latching off");
  a_otw_live: assert property (@(posedge i_clk) disable iff (!i_resetn)
    !s_q.otw_lat |-> otw_view == l_otw)
    else $error("unlatched warning does not follow condition");

  // clear command
  a_clear_drops: assert property (@(posedge i_clk) disable iff (!i_resetn)
    clr_cmd && !s_q.pready && !l_otw |=> !s_q.otw_lat)
    else $error("clear command missed warning latch");
  a_clear_clk: assert property (@(posedge i_clk) disable iff (!i_resetn)
    clr_cmd && !s_q.pready && !l_clk |=> !s_q.clk_lat)
    else $error("clear command missed clock latch");
  a_clear_otsd: assert property (@(posedge i_clk) disable iff (!i_resetn)
    clr_cmd && !s_q.pready && !l_otsd |=> !s_q.otsd_lat)
    else $error("clear command missed shutdown latch");
  a_clear_reads_zero: assert property (@(posedge i_clk) disable iff (!i_resetn)
    rd && !s_q.pready && idx == IDX_FAULT_CLR |=> o_prdata == 32'h0000_0000)
    else $error("clear command bit read back");

  // shutdown hold
  a_shutdown_set: assert property (@(posedge i_clk) disable iff (!i_resetn)
    l_otsd |=> s_q.shut_hold)
    else $error("shutdown not held");
  a_auto_recover: assert property (@(posedge i_clk) disable iff (!i_resetn)
    !l_otsd && s_q.behav_cfg[BC_AUTO_REC] |=> !s_q.shut_hold)
    else $error("no auto recovery");
  a_shutdown_stays: assert property (@(posedge i_clk) disable iff (!i_resetn)
    s_q.shut_hold && !s_q.behav_cfg[BC_AUTO_REC] && !(clr_cmd && !s_q.pready) |=> s_q.shut_hold)
    else $error("shutdown released without recovery or clear");

  // status views and masks
  a_otw_mask: assert property (@(posedge i_clk) disable iff (!i_resetn)
    s_q.latch_cfg[LC_OTW_MASK] |-> !tw_v[TW_OTW])
    else $error("masked warning reported");
  a_dc_mask: assert property (@(posedge i_clk) disable iff (!i_resetn)
    s_q.mask[MK_DC] |-> chan_v[3:2] == 2'b00)
    else $error("masked dc fault reported");
  a_oc_mask: assert property (@(posedge i_clk) disable iff (!i_resetn)
    s_q.mask[MK_OC] |-> chan_v[1:0] == 2'b00)
    else $error("masked overcurrent fault reported");
  a_clk_mask: assert property (@(posedge i_clk) disable iff (!i_resetn)
    s_q.mask[MK_CLK] |-> !dfa_v[DA_CLK])
    else $error("masked clock fault reported");
  a_pwr_mask: assert property (@(posedge i_clk) disable iff (!i_resetn)
    s_q.mask[MK_PWR_OV] |-> !dfa_v[DA_PVDD_OV])
    else $error("masked supply overvoltage reported");
  a_otsd_mask: assert property (@(posedge i_clk) disable iff (!i_resetn)
    s_q.mask[MK_OTSD] |-> !dfb_v[DB_OTSD])
    else $error("masked shutdown reported");
  a_left_dc_view: assert property (@(posedge i_clk) disable iff (!i_resetn)
    !s_q.mask[MK_DC] |-> chan_v[CH_LEFT_DC] == l_ldc)
    else $error("left dc status wrong");
  a_right_oc_view: assert property (@(posedge i_clk) disable iff (!i_resetn)
    !s_q.mask[MK_OC] |-> chan_v[CH_RIGHT_OC] == l_roc)
    else $error("right overcurrent status wrong");
  a_chan_res: assert property (@(posedge i_clk) disable iff (!i_resetn)
    chan_v[7:4] == 4'h0)
    else $error("channel reserved bits set");
  a_crc_view: assert property (@(posedge i_clk) disable iff (!i_resetn)
    dfa_v[DA_CRC] == l_crc && dfa_v[5:3] == 3'h0)
    else $error("crc status wrong");
  a_coef_view: assert property (@(posedge i_clk) disable iff (!i_resetn)
    dfa_v[DA_COEF_WR] == l_bq)
    else $error("coefficient write status wrong");
  a_dfb_res: assert property (@(posedge i_clk) disable iff (!i_resetn)
    dfb_v[7:1] == 7'h00)
    else $error("reserved bits set");
  a_tw_res: assert property (@(posedge i_clk) disable iff (!i_resetn)
    tw_v[7:3] == 5'h00 && tw_v[1:0] == 2'h0)
    else $error("warning reserved bits set");
  a_mask_write: assert property (@(posedge i_clk) disable iff (!i_resetn)
    wr && !s_q.pready && i_pstrb[0] && idx == IDX_REPORT_MASK |=> s_q.mask == $past(wb))
    else $error("mask write lost");

  // bus and interrupt
  a_apb_answer: assert property (@(posedge i_clk) disable iff (!i_resetn)
    i_psel && !i_penable ##1 i_psel && i_penable |=> o_pready)
    else $error("apb answer late");
  a_pready_pulse: assert property (@(posedge i_clk) disable iff (!i_resetn)
    o_pready |=> !o_pready)
    else $error("pready longer than one cycle");
  a_slverr_pair: assert property (@(posedge i_clk) disable iff (!i_resetn)
    o_pslverr |-> o_pready)
    else $error("error without ready");
  a_prdata_idle: assert property (@(posedge i_clk) disable iff (!i_resetn)
    !o_pready |-> o_prdata == 32'h0000_0000)
    else $error("read data outside answer");
  a_irq_level: assert property (@(posedge i_clk) disable iff (!i_resetn)
    o_irq == |(s_q.irq_st & s_q.irq_mask))
    else $error("interrupt level wrong");

  c_otsd_latched: cover property (@(posedge i_clk) disable iff (!i_resetn) s_q.otsd_lat ##1 !s_q.otsd_lat);
  c_irq_raise: cover property (@(posedge i_clk) disable iff (!i_resetn) $rose(o_irq));
  c_auto_rec: cover property (@(posedge i_clk) disable iff (!i_resetn)
    $fell(s_q.shut_hold) && s_q.behav_cfg[BC_AUTO_REC]);
  c_clk_latched: cover property (@(posedge i_clk) disable iff (!i_resetn) $rose(s_q.clk_lat));
  c_clear_warn: cover property (@(posedge i_clk) disable iff (!i_resetn) clr_cmd && s_q.otw_lat);
endmodule : afs_fault_regs

/* File: testbench/test_afs_fault_regs.sv */
// self-checking bench of the amplifier fault register bank
`timescale 1ns/1ps
module test_afs_fault_regs;
  import afs_pkg::*;
  logic i_clk = 0;
  logic i_resetn = 0;
  logic psel = 0;
  logic pen = 0;
  logic pwr = 0;
  logic [ADDR_W-1:0] padr = '0;
  logic [31:0] pwd = '0;
  logic [31:0] rd;
  logic er;
  logic [12:0] f = '0;
  logic o_pready, o_pslverr, o_shutdown_hold, o_fault_report, o_irq;
  logic [31:0] o_prdata;
  logic [7:0] m, c, b;
  logic l_sd, l_tw, l_ck;
  logic [7:0] ridx [10] = '{8'h70, 8'h71, 8'h72, 8'h73, 8'h74, 8'h75, 8'h76, 8'h78, 8'h7C, 8'h7D};
  int err_total = 0;
  int num_checks = 0;
  int seed = 60;
  afs_fault_regs uut (.i_clk(i_clk), .i_resetn(i_resetn), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
    .i_paddr(padr), .i_pwdata(pwd), .i_pstrb(4'hF), .o_pready(o_pready), .o_pslverr(o_pslverr),
    .o_prdata(o_prdata), .i_left_dc_fault(f[0]), .i_right_dc_fault(f[1]), .i_left_overcurrent_fault(f[2]),
    .i_right_overcurrent_fault(f[3]), .i_crc_error(f[4]), .i_coef_write_failure(f[5]), .i_clock_fault(f[6]),
    .i_power_supply_overvoltage(f[7]), .i_power_supply_undervoltage(f[8]), .i_core_supply_overvoltage(f[9]),
    .i_core_supply_undervoltage(f[10]), .i_thermal_shutdown_fault(f[11]), .i_thermal_warning_flag(f[12]),
    .o_shutdown_hold(o_shutdown_hold), .o_fault_report(o_fault_report), .o_irq(o_irq));
  initial begin
    forever #50 i_clk = ~i_clk;
  end
  function int rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  // expected read value, built from live inputs, config copies and latch copies
  function automatic logic [31:0] model(logic [7:0] idx);
    logic [7:0] r;
    r = 8'h00;
    case (idx)
      8'h70: r = {4'h0, f[0] & ~m[1], f[1] & ~m[1], f[2] & ~m[0], f[3] & ~m[0]};
      8'h71: r = {f[4], f[5], 3'h0, (f[6] | l_ck) & ~m[4], f[7] & ~m[2], f[8] & ~m[3]};
      8'h72: r = {7'h0, (f[11] | l_sd) & ~m[7]};
      8'h73: r = {5'h0, (f[12] | l_tw) & ~c[2], 2'h0};
      8'h74: r = m;
      8'h75: r = c;
      8'h76: r = b;
      default: r = 8'h00;
    endcase
    return {24'h0, r};
  endfunction : model
  task complete_run();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : complete_run
  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR at %0t got %0h exp %0h", $time, got, exp);
    end
  endtask : chk
  task upd();
    if (f[11] & c[4]) l_sd = 1;
    if (f[12] & c[3]) l_tw = 1;
    if (f[6] & c[5] & b[7]) l_ck = 1;
  endtask : upd
  task tick(input int n);
    repeat (n) @(posedge i_clk);
  endtask : tick
  // request held from setup until pready is seen high at a rising edge
  task apb(input logic w, input logic [7:0] idx, input logic [7:0] v);
    int n;
    n = 0;
    @(posedge i_clk);
    psel <= 1;
    pwr <= w;
    padr <= {idx, 2'b00};
    pwd <= {24'h0, v};
    @(posedge i_clk);
    pen <= 1;
    do begin
      @(posedge i_clk);
      n++;
    end while (o_pready !== 1'b1 && n < 20);
    rd = o_prdata;
    er = o_pslverr;
    psel <= 0;
    pen <= 0;
    if (n >= 20) begin
      err_total++;
      complete_run();
    end
    if (w && er === 1'b0) begin
      if (idx == 8'h74) m = v;
      if (idx == 8'h75) c = v;
      if (idx == 8'h76) b = v;
      if (idx == 8'h78 && v[7]) begin
        {l_sd, l_tw, l_ck} = 3'b000;
        upd();
      end
    end
  endtask : apb
  task rdc(input logic [7:0] idx);
    apb(0, idx, 8'h00);
    chk(rd, model(idx));
  endtask : rdc
  // faults are levels held long enough to pass the two-flop synchronisers
  task set_f(input logic [12:0] v);
    @(posedge i_clk);
    f <= v;
    tick(4);
    upd();
  endtask : set_f
  initial begin
    m = 8'h00;
    c = 8'hF8;
    b = 8'h00;
    {l_sd, l_tw, l_ck} = 3'b000;
    tick(8);
    i_resetn <= 1;
    for (int i = 0; i < 10; i++) rdc(ridx[i]);
    apb(0, 8'h77, 8'h00);
    chk({31'h0, er}, 32'h1);
    for (int i = 0; i < 3; i++) begin
      apb(1, 8'h74 + 8'(i), 8'(rnd()));
      rdc(8'h74 + 8'(i));
    end
    apb(1, 8'h74, 8'h00);
    apb(1, 8'h75, 8'hF8);
    apb(1, 8'h76, 8'h00);
    apb(1, 8'h70, 8'hFF);
    rdc(8'h70);
    repeat (8) begin
      apb(1, 8'h74, 8'(rnd()));
      set_f(13'(rnd()) & 13'h07FF);
      for (int i = 0; i < 4; i++) rdc(ridx[i]);
    end
    apb(1, 8'h74, 8'h00);
    set_f(13'h0000);
    apb(1, 8'h76, 8'h80);
    set_f(13'h0040);
    set_f(13'h0000);
    rdc(8'h71);
    apb(1, 8'h78, 8'h80);
    rdc(8'h71);
    apb(1, 8'h76, 8'h00);
    set_f(13'h0040);
    set_f(13'h0000);
    rdc(8'h71);
    apb(1, 8'h7C, 8'hFF);
    apb(1, 8'h7D, 8'h10);
    set_f(13'h0800);
    chk({31'h0, o_shutdown_hold}, 32'h1);
    chk({31'h0, o_irq}, 32'h1);
    set_f(13'h0000);
    rdc(8'h72);
    chk({31'h0, o_shutdown_hold}, 32'h1);
    apb(1, 8'h7C, 8'h10);
    apb(0, 8'h7C, 8'h00);
    chk(rd, 32'h0);
    apb(1, 8'h78, 8'h80);
    rdc(8'h72);
    tick(2);
    chk({31'h0, o_shutdown_hold | o_irq}, 32'h0);
    apb(1, 8'h74, 8'h80);
    set_f(13'h0800);
    rdc(8'h72);
    apb(1, 8'h76, 8'h10);
    set_f(13'h0000);
    tick(4);
    chk({31'h0, o_shutdown_hold}, 32'h0);
    apb(1, 8'h78, 8'h80);
    apb(1, 8'h74, 8'h00);
    set_f(13'h1000);
    set_f(13'h0000);
    rdc(8'h73);
    apb(1, 8'h75, 8'hFC);
    rdc(8'h73);
    apb(1, 8'h75, 8'hF0);
    apb(1, 8'h78, 8'h80);
    rdc(8'h73);
    set_f(13'h1000);
    rdc(8'h73);
    set_f(13'h0001);
    rdc(8'h73);
    chk({31'h0, o_fault_report}, 32'h1);
    apb(1, 8'h74, 8'h02);
    tick(3);
    chk({31'h0, o_fault_report}, 32'h0);
    complete_run();
  end
endmodule : test_afs_fault_regs
